// File: fma_pkg.sv
// Shared constants and types for the fused multiply-add unit.
// Assumes a 32-bit classic Wishbone slave addressed in bytes.
package fma_pkg;
    // Register byte offsets.
    localparam logic [5:0] OFF_SRC1_LO = 6'h00;
    localparam logic [5:0] OFF_SRC1_HI = 6'h04;
    localparam logic [5:0] OFF_SRC2_LO = 6'h08;
    localparam logic [5:0] OFF_SRC2_HI = 6'h0c;
    localparam logic [5:0] OFF_SRC3_LO = 6'h10;
    localparam logic [5:0] OFF_SRC3_HI = 6'h14;
    localparam logic [5:0] OFF_RES_LO = 6'h18;
    localparam logic [5:0] OFF_RES_HI = 6'h1c;
    localparam logic [5:0] OFF_CTRL = 6'h20;
    localparam logic [5:0] OFF_FSR = 6'h24;
    localparam logic [5:0] OFF_ENABLE = 6'h28;
    localparam logic [5:0] OFF_STATUS = 6'h2c;

    // Field positions.
    localparam int CTRL_VAR_LSB = 0;
    localparam int CTRL_DBL_BIT = 2;
    localparam int CTRL_GO_BIT = 3;
    localparam int CTRL_RND_LSB = 4;
    localparam int TRAP_ENABLE_MASK_LSB = 0;
    localparam int ACCRUED_EXCEPTION_BITS_LSB = 5;
    localparam int CURRENT_EXCEPTION_BITS_LSB = 10;
    localparam int FP_TRAP_TYPE_LSB = 15;
    localparam int EXC_NV = 4;
    localparam int EXC_OF = 3;
    localparam int EXC_NX = 0;

    // Every register resets to this value.
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Exponent handling; singles are widened to the double layout.
    localparam logic signed [13:0] DBL_BIAS = 14'sh03ff;
    localparam logic [10:0] SGL_REBIAS = 11'h380;
    localparam logic signed [13:0] SGL_REBIAS_S = 14'sh0380;
    localparam logic signed [13:0] DBL_EMAX = 14'sh07ff;
    localparam logic signed [13:0] SGL_EMAX = 14'sh00ff;

    typedef enum logic [1:0] {
        fused_mul_plus, fused_mul_minus, neg_fused_mul_plus, neg_fused_mul_minus
    } variant_t;
    typedef enum logic [1:0] {rnd_nearest, rnd_zero, rnd_up, rnd_down} rnd_t;
    typedef enum logic [1:0] {ftt_none, ftt_ieee, ftt_unfinished} fp_trap_type_t;
    typedef enum logic {st_idle, st_exec} fsm_t;
endpackage : fma_pkg

// File: fp_operand_if.sv
// Carries one decoded floating-point operand between the unpacker and the datapath.
// Assumes both ends sit on the same clock; the content is combinational.
interface fp_operand_if;
    logic sign;
    logic [10:0] exp;
    logic [52:0] man;
    logic is_zero;
    logic is_sub;
    logic is_inf;
    logic is_nan;
    logic is_snan;
    modport producer(output sign, exp, man, is_zero, is_sub, is_inf, is_nan, is_snan);
    modport consumer(input sign, exp, man, is_zero, is_sub, is_inf, is_nan, is_snan);
endinterface : fp_operand_if

// File: fp_unpack.sv
// Decodes a single or double operand into a common double-width form.
// Assumes a single sits in the low 32 bits of the word.
module fp_unpack (
    input wire logic [63:0] word,
    input wire logic dbl,
    fp_operand_if.producer op
);
    logic [10:0] e;
    logic [51:0] f;
    logic e_max;
    logic sgn;

    always_comb begin
        if (dbl) begin
            sgn = word[63];
            f = word[51:0];
            e_max = &word[62:52];
            e = word[62:52];
        end else begin
            sgn = word[31];
            f = {word[22:0], 29'h0};
            e_max = &word[30:23];
            if (word[30:23] == 8'h00) begin
                e = 11'h000;
            end else if (e_max) begin
                e = 11'h7ff;
            end else begin
                e = {3'h0, word[30:23]} + fma_pkg::SGL_REBIAS;
            end
        end
    end

    assign op.sign = sgn;
    assign op.exp = e;
    assign op.man = {e != 11'h000, f};
    assign op.is_zero = (e == 11'h000) && (f == 52'h0);
    assign op.is_sub = (e == 11'h000) && (f != 52'h0);
    assign op.is_inf = e_max && (f == 52'h0);
    assign op.is_nan = e_max && (f != 52'h0);
    assign op.is_snan = e_max && (f != 52'h0) && !f[51];
endmodule : fp_unpack

// File: fused_multiply_add_unit.sv
// Fused multiply-add unit with its operand, result and status registers.
// Assumes a classic Wishbone master on ref_clk; one answer per request.
//
// What this block does
// - Plus variant rounds product plus third once.
// - Minus variant rounds product minus third once.
// - Negated plus negates sum before single rounding.
// - Negated minus negates difference before single rounding.
// - Product stays exact into the add step.
// - Negated variants keep source quiet NaN sign.
// - Generated default quiet NaN has sign zero.
// - Quieted signaling NaN keeps its own sign.
// - Unimplemented precision raises undefined-opcode fault.
// - Disabled or absent unit raises off fault.
// - Overflow and inexact come from final result.
// - Invalid flags as for separate multiply, add.
// - Invalid on signaling NaN, inf*0, inf-inf.
// - Enabled IEEE exception raises IEEE fault.
// - Subnormal operand or result raises incomplete fault unless an operand is NaN or infinity.
// - Incomplete fault wins over IEEE fault.
// - Incomplete fault leaves exception fields untouched.
module fused_multiply_add_unit #(
    parameter bit FPU_PRESENT = 1'b1,
    parameter bit IMPL_SINGLE = 1'b1,
    parameter bit IMPL_DOUBLE = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        fma_pkg::fsm_t fsm;
        logic ack;
        logic [31:0] rdata;
        logic [5:0][31:0] src;
        logic [63:0] result;
        fma_pkg::variant_t variant;
        logic dbl;
        fma_pkg::rnd_t rnd;
        logic [4:0] trap_enable_mask;
        logic [4:0] accrued_exception_bits;
        logic [4:0] current_exception_bits;
        fma_pkg::fp_trap_type_t fp_trap_type;
        logic fp_enable_status_bit;
        logic fp_enable_state_bit;
        logic done;
        logic fpu_off_fault;
        logic undef_op_fault;
        logic ieee_fp_fault;
        logic other_fp_fault;
    } state_t;

    state_t s;
    state_t n;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = sel[i] ? d[8*i +: 8] : o[8*i +: 8];
        end
    endfunction : merge

    // Right shift that folds every bit shifted out into the lowest bit.
    function automatic logic [111:0] shr(input logic [111:0] v, input logic [13:0] d);
        logic [111:0] m;
        m = (d >= 14'd112) ? {112{1'b1}} : ~({112{1'b1}} << d);
        shr = (d >= 14'd112) ? {111'h0, |v} : ((v >> d) | {111'h0, |(v & m)});
    endfunction : shr

    fp_operand_if opa();
    fp_operand_if opb();
    fp_operand_if opc();

    // Singles are widened to the double layout so one datapath serves both precisions.
    fp_unpack u_a (.word({s.src[1], s.src[0]}), .dbl(s.dbl), .op(opa));
    fp_unpack u_b (.word({s.src[3], s.src[2]}), .dbl(s.dbl), .op(opb));
    fp_unpack u_c (.word({s.src[5], s.src[4]}), .dbl(s.dbl), .op(opc));

    logic sp, sce, neg, esub, pzero, rsign, carry, g, st, inc, ovf, to_inf, found;
    logic signed [13:0] xp, xc, xr, xo, emax;
    logic [13:0] dsh;
    logic [105:0] prod;
    logic [111:0] vp, vc, ap, ac, mag, nrm;
    logic [6:0] lz;
    logic [52:0] keep;
    logic [53:0] rm;
    logic [10:0] e_all, e_f;
    logic [51:0] f_f;
    logic [63:0] res;
    logic [4:0] exc;
    logic unf;

    // Datapath: one exact sum, one rounding.
    always_comb begin
        sp = opa.sign ^ opb.sign;
        sce = opc.sign ^ (s.variant inside {fma_pkg::fused_mul_minus, fma_pkg::neg_fused_mul_minus});
        neg = s.variant inside {fma_pkg::neg_fused_mul_plus, fma_pkg::neg_fused_mul_minus};
        esub = sp ^ sce;
        pzero = opa.is_zero | opb.is_zero;
        prod = opa.man * opb.man;
        xp = $signed({3'h0, opa.exp}) + $signed({3'h0, opb.exp}) - fma_pkg::DBL_BIAS;
        xc = $signed({3'h0, opc.exp});
        vp = {2'b00, prod, 4'h0};
        vc = {3'b000, opc.man, 52'h0, 4'h0};
        if (opc.is_zero || (!pzero && xp >= xc)) begin
            xr = xp;
            dsh = 14'(xp - xc);
            ap = vp;
            ac = opc.is_zero ? 112'h0 : shr(vc, dsh);
        end else begin
            xr = xc;
            dsh = 14'(xc - xp);
            ac = vc;
            ap = pzero ? 112'h0 : shr(vp, dsh);
        end
        // The wide field keeps the product exact, so only the final step rounds.
        if (!esub) begin
            mag = ap + ac;
            rsign = sp;
        end else if (ap >= ac) begin
            mag = ap - ac;
            rsign = sp;
        end else begin
            mag = ac - ap;
            rsign = sce;
        end
        if (mag == 112'h0 && esub) begin
            rsign = (s.rnd == fma_pkg::rnd_down);
        end
        rsign = rsign ^ neg;
        lz = 7'd0;
        found = 1'b0;
        for (int i = 111; i >= 0; i--) begin
            if (!found && mag[i]) begin
                lz = 7'(111 - i);
                found = 1'b1;
            end
        end
        nrm = mag << lz;
        xo = xr + 14'sd3 - $signed({7'h0, lz});
        if (s.dbl) begin
            keep = nrm[111:59];
            g = nrm[58];
            st = |nrm[57:0];
            emax = fma_pkg::DBL_EMAX;
            e_all = 11'h7ff;
        end else begin
            keep = {29'h0, nrm[111:88]};
            g = nrm[87];
            st = |nrm[86:0];
            xo = xo - fma_pkg::SGL_REBIAS_S;
            emax = fma_pkg::SGL_EMAX;
            e_all = 11'h0ff;
        end
        unique case (s.rnd)
            fma_pkg::rnd_nearest: inc = g & (st | keep[0]);
            fma_pkg::rnd_zero: inc = 1'b0;
            fma_pkg::rnd_up: inc = ~rsign & (g | st);
            fma_pkg::rnd_down: inc = rsign & (g | st);
        endcase
        rm = {1'b0, keep} + {53'h0, inc};
        carry = s.dbl ? rm[53] : rm[24];
        if (carry) begin
            rm = rm >> 1;
            xo = xo + 14'sd1;
        end
        // An all-ones exponent already encodes infinity, hence greater-or-equal.
        ovf = xo >= emax;
        // Directed modes pointing away from the sign saturate to the largest finite value.
        to_inf = (s.rnd == fma_pkg::rnd_nearest) || (s.rnd == fma_pkg::rnd_up && !rsign)
            || (s.rnd == fma_pkg::rnd_down && rsign);
        exc = 5'h00;
        // Tiny results never round here; they go to the incomplete path instead.
        unf = opa.is_sub | opb.is_sub | opc.is_sub | (mag != 112'h0 && xo <= 14'sd0);
        e_f = xo[10:0];
        f_f = s.dbl ? rm[51:0] : {rm[22:0], 29'h0};
        if (opa.is_snan | opb.is_snan | opc.is_snan | opa.is_nan | opb.is_nan | opc.is_nan) begin
            unf = 1'b0;
            // Operand three is the fallback; a signaling NaN outranks a quiet one in operand order.
            rsign = opc.sign;
            f_f = opc.man[51:0];
            if (opa.is_snan | (opa.is_nan & ~opb.is_snan & ~opc.is_snan)) begin
                rsign = opa.sign;
                f_f = opa.man[51:0];
            end else if (opb.is_snan | (opb.is_nan & ~opc.is_snan)) begin
                rsign = opb.sign;
                f_f = opb.man[51:0];
            end
            f_f[51] = 1'b1;
            e_f = e_all;
            // Invalid as though multiply and add ran apart.
            exc[fma_pkg::EXC_NV] = opa.is_snan | opb.is_snan | opc.is_snan
                | (opa.is_inf & opb.is_zero) | (opb.is_inf & opa.is_zero);
        end else if ((opa.is_inf & opb.is_zero) | (opb.is_inf & opa.is_zero)
            | ((opa.is_inf | opb.is_inf) & opc.is_inf & esub)) begin
            unf = 1'b0;
            rsign = 1'b0;
            e_f = e_all;
            f_f = {1'b1, 51'h0};
            exc[fma_pkg::EXC_NV] = 1'b1;
        end else if (opa.is_inf | opb.is_inf | opc.is_inf) begin
            unf = 1'b0;
            rsign = ((opa.is_inf | opb.is_inf) ? sp : sce) ^ neg;
            e_f = e_all;
            f_f = 52'h0;
        end else if (mag == 112'h0) begin
            e_f = 11'h000;
            f_f = 52'h0;
        end else if (ovf) begin
            exc[fma_pkg::EXC_OF] = 1'b1;
            exc[fma_pkg::EXC_NX] = 1'b1;
            e_f = to_inf ? e_all : e_all - 11'h001;
            f_f = to_inf ? 52'h0 : {52{1'b1}};
        end else begin
            exc[fma_pkg::EXC_NX] = g | st;
        end
        res = s.dbl ? {rsign, e_f, f_f} : {32'h0, rsign, e_f[7:0], f_f[51:29]};
    end

    // Bus slave, configuration and instruction sequencing.
    always_comb begin
        logic [31:0] rd;
        logic [31:0] w;
        logic req;
        logic wr_now;
        rd = fma_pkg::REG_RESET;
        w = fma_pkg::REG_RESET;
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        // A write lands only at the edge where the master sees ack high,
        // so a request dropped before its answer changes nothing.
        wr_now = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
        n = s;
        n.ack = req;
        unique case (wb_adr_i & 6'h3c)
            fma_pkg::OFF_SRC1_LO: rd = s.src[0];
            fma_pkg::OFF_SRC1_HI: rd = s.src[1];
            fma_pkg::OFF_SRC2_LO: rd = s.src[2];
            fma_pkg::OFF_SRC2_HI: rd = s.src[3];
            fma_pkg::OFF_SRC3_LO: rd = s.src[4];
            fma_pkg::OFF_SRC3_HI: rd = s.src[5];
            fma_pkg::OFF_RES_LO: rd = s.result[31:0];
            fma_pkg::OFF_RES_HI: rd = s.result[63:32];
            fma_pkg::OFF_CTRL: begin
                rd[fma_pkg::CTRL_VAR_LSB +: 2] = s.variant;
                rd[fma_pkg::CTRL_DBL_BIT] = s.dbl;
                rd[fma_pkg::CTRL_RND_LSB +: 2] = s.rnd;
            end
            fma_pkg::OFF_FSR: begin
                rd[fma_pkg::TRAP_ENABLE_MASK_LSB +: 5] = s.trap_enable_mask;
                rd[fma_pkg::ACCRUED_EXCEPTION_BITS_LSB +: 5] = s.accrued_exception_bits;
                rd[fma_pkg::CURRENT_EXCEPTION_BITS_LSB +: 5] = s.current_exception_bits;
                rd[fma_pkg::FP_TRAP_TYPE_LSB +: 2] = s.fp_trap_type;
            end
            fma_pkg::OFF_ENABLE: rd[1:0] = {s.fp_enable_state_bit, s.fp_enable_status_bit};
            fma_pkg::OFF_STATUS: rd[5:0] = {s.other_fp_fault, s.ieee_fp_fault, s.undef_op_fault,
                s.fpu_off_fault, s.done, s.fsm == fma_pkg::st_exec};
            default: rd = fma_pkg::REG_RESET;
        endcase
        // Read data is zero outside the answer cycle so a stale word never looks valid.
        n.rdata = req ? rd : fma_pkg::REG_RESET;
        w = merge(rd, wb_dat_i, wb_sel_i);
        if (wr_now) begin
            unique case (wb_adr_i & 6'h3c)
                fma_pkg::OFF_SRC1_LO: n.src[0] = w;
                fma_pkg::OFF_SRC1_HI: n.src[1] = w;
                fma_pkg::OFF_SRC2_LO: n.src[2] = w;
                fma_pkg::OFF_SRC2_HI: n.src[3] = w;
                fma_pkg::OFF_SRC3_LO: n.src[4] = w;
                fma_pkg::OFF_SRC3_HI: n.src[5] = w;
                fma_pkg::OFF_CTRL: begin
                    // A start while busy is dropped so operands stay stable mid-flight.
                    if (s.fsm == fma_pkg::st_idle) begin
                        n.variant = fma_pkg::variant_t'(w[fma_pkg::CTRL_VAR_LSB +: 2]);
                        n.dbl = w[fma_pkg::CTRL_DBL_BIT];
                        n.rnd = fma_pkg::rnd_t'(w[fma_pkg::CTRL_RND_LSB +: 2]);
                        if (wb_sel_i[0] && w[fma_pkg::CTRL_GO_BIT]) begin
                            n.fsm = fma_pkg::st_exec;
                            n.done = 1'b0;
                            n.fpu_off_fault = 1'b0;
                            n.undef_op_fault = 1'b0;
                            n.ieee_fp_fault = 1'b0;
                            n.other_fp_fault = 1'b0;
                        end
                    end
                end
                fma_pkg::OFF_FSR: begin
                    n.trap_enable_mask = w[fma_pkg::TRAP_ENABLE_MASK_LSB +: 5];
                    n.accrued_exception_bits = w[fma_pkg::ACCRUED_EXCEPTION_BITS_LSB +: 5];
                    n.current_exception_bits = w[fma_pkg::CURRENT_EXCEPTION_BITS_LSB +: 5];
                end
                fma_pkg::OFF_ENABLE: begin
                    n.fp_enable_status_bit = w[0];
                    n.fp_enable_state_bit = w[1];
                end
                default: n.rdata = n.rdata;
            endcase
        end
        // Completion comes after the bus so a hardware update beats a same-cycle write.
        if (s.fsm == fma_pkg::st_exec) begin
            n.fsm = fma_pkg::st_idle;
            n.done = 1'b1;
            if (s.dbl ? !IMPL_DOUBLE : !IMPL_SINGLE) begin
                n.undef_op_fault = 1'b1;
            end else if (!FPU_PRESENT || !s.fp_enable_status_bit || !s.fp_enable_state_bit) begin
                n.fpu_off_fault = 1'b1;
            end else if (unf) begin
                // Exception fields are left as they were.
                n.other_fp_fault = 1'b1;
                n.fp_trap_type = fma_pkg::ftt_unfinished;
                n.current_exception_bits = s.current_exception_bits;
                n.accrued_exception_bits = s.accrued_exception_bits;
            end else if (|(exc & s.trap_enable_mask)) begin
                n.ieee_fp_fault = 1'b1;
                n.fp_trap_type = fma_pkg::ftt_ieee;
                n.current_exception_bits = exc;
            end else begin
                n.result = res;
                n.fp_trap_type = fma_pkg::ftt_none;
                n.current_exception_bits = exc;
                n.accrued_exception_bits = s.accrued_exception_bits | exc;
            end
        end
    end

    // Zero is the reset value of every register, so the whole state clears at once.
    // The reset branch holds only constants, keeping the asynchronous path clean.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= state_t'(0);
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
endmodule : fused_multiply_add_unit

// File: fma_checker_assertions.sv
// Bus timing and status read-back checks for the fused multiply-add unit.
// Assumes it is bound to the top module and sees only its ports.
module fma_checker #(
    parameter bit FPU_PRESENT = 1'b1,
    parameter bit IMPL_SINGLE = 1'b1,
    parameter bit IMPL_DOUBLE = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    typedef struct packed {logic [1:0] en; logic [1:0] en_go; logic dbl; logic seen;} chk_t;
    chk_t st;
    chk_t next_st;
    wire logic take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire logic rd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
    wire logic [3:0] wa = wb_adr_i[5:2];
    wire logic rd_st = rd && wa == fma_pkg::OFF_STATUS[5:2];
    // The enable bits are captured at go, since software may change them afterwards.
    always_comb begin
        next_st = st;
        if (take && wa == fma_pkg::OFF_ENABLE[5:2]) next_st.en = wb_dat_i[1:0];
        if (take && wa == fma_pkg::OFF_CTRL[5:2] && wb_dat_i[3]) begin
            next_st.en_go = st.en;
            next_st.dbl = wb_dat_i[2];
            next_st.seen = 1'b1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) st <= '0;
        else st <= next_st;
    end
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_answer; s_req |=> s_pulse; endproperty
    property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_status; rd_st |-> wb_dat_o[31:6] == 26'h0 && !wb_dat_o[0]; endproperty
    property p_one_fault; rd_st |-> $onehot0(wb_dat_o[5:2]); endproperty
    property p_off; rd_st && st.seen |->
        wb_dat_o[2] == ((st.dbl ? IMPL_DOUBLE : IMPL_SINGLE) && (st.en_go != 2'b11 || !FPU_PRESENT)); endproperty
    property p_undef; rd_st && st.seen |-> wb_dat_o[3] == (st.dbl ? !IMPL_DOUBLE : !IMPL_SINGLE); endproperty
    property p_ftt; rd && wa == fma_pkg::OFF_FSR[5:2] |-> wb_dat_o[16:15] != 2'b11 && wb_dat_o[31:17] == 15'h0;
    endproperty
    property p_ctrl; rd && wa == fma_pkg::OFF_CTRL[5:2] |-> !wb_dat_o[3] && wb_dat_o[31:6] == 26'h0; endproperty
    property p_hi; rd && wa == fma_pkg::OFF_RES_HI[5:2] && st.seen && !st.dbl |-> wb_dat_o == 32'h0; endproperty
    a_answer: assert property (p_answer) else $error("ack not a one-cycle answer");
    a_cause: assert property (p_cause) else $error("ack without request");
    a_idle: assert property (p_idle) else $error("read data not zero outside ack");
    a_status: assert property (p_status) else $error("status busy or spare bits set");
    a_one_fault: assert property (p_one_fault) else $error("more than one fault flag");
    a_off: assert property (p_off) else $error("off fault flag wrong");
    a_undef: assert property (p_undef) else $error("undefined-opcode flag wrong");
    a_ftt: assert property (p_ftt) else $error("trap type field illegal");
    a_ctrl: assert property (p_ctrl) else $error("control reads go or spare bits");
    a_hi: assert property (p_hi) else $error("single result high word not zero");
endmodule : fma_checker

bind fused_multiply_add_unit fma_checker #(.FPU_PRESENT(FPU_PRESENT), .IMPL_SINGLE(IMPL_SINGLE),
    .IMPL_DOUBLE(IMPL_DOUBLE)) i_fma_checker (
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// File: wb_master_model.sv
// Classic Wishbone master standing in for the instruction issue side.
// Assumes the slave acks every request; it waits for ack without limit.
module wb_master_model (
    input wire logic ref_clk,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [5:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i
);
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 6'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end
    task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        // Released address and data lines show inverted values so stale data cannot pass as valid.
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_adr_i <= ~a;
        wb_sel_i <= 4'h0;
        wb_dat_i <= ~d;
    endtask : xfer
endmodule : wb_master_model

// File: testbench.sv
// Self-checking bench for the fused multiply-add unit.
// Assumes the master model performs every register access.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    fused_multiply_add_unit i_fused_multiply_add_unit (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    wb_master_model i_wb_master_model (.ref_clk(ref_clk), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_wb_master_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_wb_master_model.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rdchk
    // Every operation ends with done set, faulted or not.
    task automatic run(input logic [31:0] f, input logic [5:0] c, input logic [63:0] a, b, s3, r,
                       input logic [31:0] fe, se);
        wr(fma_pkg::OFF_FSR, f);
        wr(fma_pkg::OFF_SRC1_LO, a[31:0]);
        wr(fma_pkg::OFF_SRC1_HI, a[63:32]);
        wr(fma_pkg::OFF_SRC2_LO, b[31:0]);
        wr(fma_pkg::OFF_SRC2_HI, b[63:32]);
        wr(fma_pkg::OFF_SRC3_LO, s3[31:0]);
        wr(fma_pkg::OFF_SRC3_HI, s3[63:32]);
        wr(fma_pkg::OFF_CTRL, {26'h0, c} | 32'h8);
        rdchk(fma_pkg::OFF_RES_LO, r[31:0]);
        rdchk(fma_pkg::OFF_RES_HI, r[63:32]);
        rdchk(fma_pkg::OFF_FSR, fe);
        rdchk(fma_pkg::OFF_STATUS, se | 32'h2);
    endtask : run
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        wr(fma_pkg::OFF_RES_LO, 32'hffffffff);
        wr(fma_pkg::OFF_STATUS, 32'hffffffff);
        wr(6'h30, 32'hffffffff);
        for (int i = 0; i < 13; i++) rdchk(6'(i * 4), fma_pkg::REG_RESET);
        for (int e = 0; e < 3; e++) begin
            wr(fma_pkg::OFF_ENABLE, 32'(e));
            run(0, 6'h0, 64'h40000000, 64'h40400000, 64'h3f800000, 64'h0, 0, 32'h4);
        end
        wr(fma_pkg::OFF_ENABLE, 32'h3);
        rdchk(fma_pkg::OFF_ENABLE, 32'h3);
        for (int v = 0; v < 4; v++) begin
            run(0, 6'(v) | 6'h4, 64'h4000000000000000, 64'h4008000000000000, 64'h3ff0000000000000,
                {v[1], v[0] ? 63'h4014000000000000 : 63'h401c000000000000}, 0, 2);
            run(0, 6'(v), 64'h40000000, 64'h40400000, 64'h3f800000,
                {32'h0, v[1], v[0] ? 31'h40a00000 : 31'h40e00000}, 0, 2);
        end
        run(0, 6'h0, 64'h3f800800, 64'h3f800800, 64'hbf800000, 64'h3a000400, 0, 2);
        for (int m = 0; m < 4; m++) begin
            run(0, 6'(m << 4), 64'h3f800001, 64'h3f800001, 64'h0,
                m == 2 ? 64'h3f800003 : 64'h3f800002, 32'h420, 2);
        end
        run(0, 6'h0, 64'h7f000000, 64'h40800000, 64'h0, 64'h7f800000, 32'h2520, 2);
        run(0, 6'h2, 64'h7f800000, 64'h0, 64'h3f800000, 64'h7fc00000, 32'h4200, 2);
        run(0, 6'h3, 64'h7f800000, 64'h3f800000, 64'h7f800000, 64'h7fc00000, 32'h4200, 2);
        run(0, 6'h2, 64'hff800001, 64'h3f800000, 64'h3f800000, 64'hffc00001, 32'h4200, 2);
        run(0, 6'h3, 64'h3f800000, 64'h3f800000, 64'hffc00005, 64'hffc00005, 0, 2);
        run(32'h10, 6'h2, 64'h7f800000, 64'h0, 64'h3f800000, 64'hffc00005, 32'hc010, 32'h10);
        run(32'h43f, 6'h0, 64'h1, 64'h3f800000, 64'h0, 64'hffc00005, 32'h1043f, 32'h20);
        run(32'h43f, 6'h0, 64'h0d800001, 64'h30800001, 64'h0, 64'hffc00005, 32'h1043f, 32'h20);
        conclude();
    end
endmodule : testbench
